// >>> verilog/vis_voice_id_selector.sv
// Voice ID selector: scans the stored ID message and chooses voice or Morse backup.
module vis_voice_id_selector (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_id_start,
	input wire logic i_carrier_detect_input,
	output logic [vis_pkg::ADDR_W-1:0] o_msg_addr,
	output logic o_msg_rd,
	input wire logic [vis_pkg::CHAR_W-1:0] i_msg_data,
	output vis_pkg::vis_char_t o_morse,
	input wire logic i_morse_ready,
	output logic o_playback_button,
	input wire logic i_voice_audio,
	output logic o_tx_audio,
	output logic o_voice_mode,
	output logic o_busy,
	output logic o_done
);
	import vis_pkg::*;

	vis_state_t state, next_state;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [CHAR_W-1:0] pend0, next_pend0, pend1, next_pend1;
	logic [1:0] match, next_match;
	logic [1:0] flush, next_flush;
	logic carrier_at_start, next_carrier_at_start;
	logic after_marker, next_after_marker;
	logic voice_mode, next_voice_mode;
	vis_char_t morse, next_morse;
	logic rd, next_rd;
	logic pulse, next_pulse;
	logic done, next_done;
	logic busy, next_busy;
	logic tx_audio;
	logic carrier_sync;

	vis_sync u_carrier_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_carrier_detect_input),
		.o_sync(carrier_sync)
	);

	// Characters that might open the marker are held back until the marker either
	// completes or fails, so a lone colon in the text is still sent.
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_pend0 = pend0;
		next_pend1 = pend1;
		next_match = match;
		next_flush = flush;
		next_carrier_at_start = carrier_at_start;
		next_after_marker = after_marker;
		next_voice_mode = voice_mode;
		next_morse = morse;
		next_rd = 1'b0;
		next_pulse = 1'b0;
		next_done = 1'b0;
		if (morse.valid && i_morse_ready) begin
			next_morse.valid = 1'b0;
		end
		case (state)
			ST_IDLE: begin
				if (i_id_start) begin
					// The carrier is sampled once here and held for the whole ID.
					next_carrier_at_start = carrier_sync;
					next_addr = ADDR_ZERO;
					next_match = MATCH_ZERO;
					next_flush = MATCH_ZERO;
					next_after_marker = 1'b0;
					next_voice_mode = 1'b0;
					next_rd = 1'b1;
					next_state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (!next_morse.valid) begin
					if (flush != MATCH_ZERO) begin
						next_morse.valid = 1'b1;
						next_morse.data = pend0;
						next_pend0 = pend1;
						next_flush = flush - MATCH_ONE;
					end else if (i_msg_data == CH_END && match == MATCH_ZERO) begin
						// A prefix still held at the end of the text is flushed by the branch below first.
						next_state = ST_DONE;
					end else if (after_marker) begin
						next_morse.valid = 1'b1;
						next_morse.data = i_msg_data;
						next_state = ST_SEND;
					end else if (i_msg_data == CH_COLON && match != MATCH_ONE) begin
						if (match == MATCH_TWO) begin
							next_voice_mode = 1'b1;
							next_after_marker = 1'b1;
							next_match = MATCH_ZERO;
							if (carrier_at_start) begin
								next_state = ST_SEND;
							end else begin
								next_pulse = 1'b1;
								next_state = ST_VOICE;
							end
						end else begin
							next_pend0 = i_msg_data;
							next_match = MATCH_ONE;
							next_state = ST_SEND;
						end
					end else if (match == MATCH_ONE && (i_msg_data == CH_V_UP || i_msg_data == CH_V_LO)) begin
						next_pend1 = i_msg_data;
						next_match = MATCH_TWO;
						next_state = ST_SEND;
					end else if (match != MATCH_ZERO) begin
						next_flush = match;
						next_match = MATCH_ZERO;
					end else begin
						next_morse.valid = 1'b1;
						next_morse.data = i_msg_data;
						next_state = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				// A message that fills every address stops at the last one, so a prefix held there is lost.
				next_addr = addr + ADDR_ONE;
				next_rd = 1'b1;
				next_state = (addr == {ADDR_W{1'b1}}) ? ST_DONE : ST_FETCH;
			end
			ST_VOICE: begin
				// The backup text is skipped; nothing checks that a board answered.
				next_state = ST_DONE;
			end
			ST_DONE: begin
				if (!next_morse.valid) begin
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Busy is registered from the next state so the output needs no decode after the flip-flop.
		next_busy = (next_state != ST_IDLE);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			addr <= ADDR_ZERO;
			pend0 <= CH_END;
			pend1 <= CH_END;
			match <= MATCH_ZERO;
			flush <= MATCH_ZERO;
			carrier_at_start <= 1'b0;
			after_marker <= 1'b0;
			voice_mode <= 1'b0;
			morse <= '0;
			rd <= 1'b0;
			pulse <= 1'b0;
			done <= 1'b0;
			busy <= 1'b0;
			tx_audio <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			pend0 <= next_pend0;
			pend1 <= next_pend1;
			match <= next_match;
			flush <= next_flush;
			carrier_at_start <= next_carrier_at_start;
			after_marker <= next_after_marker;
			voice_mode <= next_voice_mode;
			morse <= next_morse;
			rd <= next_rd;
			pulse <= next_pulse;
			done <= next_done;
			busy <= next_busy;
			tx_audio <= i_voice_audio;
		end
	end

	assign o_msg_addr = addr;
	assign o_msg_rd = rd;
	assign o_morse = morse;
	assign o_playback_button = pulse;
	assign o_tx_audio = tx_audio;
	assign o_voice_mode = voice_mode;
	assign o_busy = busy;
	assign o_done = done;

	// The pulse, the state register and the voice flags all change on one edge, so the
	// voice checks look at them in the same cycle rather than one apart.
	a_pulse_single: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pulse |=> !pulse) else $error("playback pulse longer than one cycle");
	a_no_voice_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pulse |-> !carrier_at_start) else $error("playback with carrier active");
	a_carrier_once: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state != ST_IDLE) |=> $stable(carrier_at_start)) else $error("carrier resampled during ID");
	a_backup_send: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state == ST_WAIT && after_marker && carrier_at_start && !morse.valid && i_msg_data != CH_END)
		|=> (morse.valid && morse.data == $past(i_msg_data))) else $error("backup character not sent");
	a_voice_marks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pulse |-> voice_mode && after_marker) else $error("pulse without marker");
	a_voice_skip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pulse |-> (state == ST_VOICE && !morse.valid) ##1 (state == ST_DONE && !morse.valid)
		##1 (done && state == ST_IDLE)) else $error("backup not skipped");
	a_audio_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_tx_audio == $past(i_voice_audio)) else $error("audio not routed");
	a_pre_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pulse |-> (flush == MATCH_ZERO && !morse.valid)) else $error("pending text left before voice");
	a_start_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state == ST_IDLE && i_id_start) |=> carrier_at_start == $past(carrier_sync))
		else $error("carrier not sampled at start");
	a_no_sense: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state == ST_VOICE) |=> (state == ST_DONE)) else $error("voice waits on board");
	// Covers mark the voice, backup, plain, flushed-prefix and ignored-restart runs.
	c_voice: cover property (@(posedge i_clk_sys) pulse);
	c_backup: cover property (@(posedge i_clk_sys) morse.valid && after_marker);
	c_plain: cover property (@(posedge i_clk_sys) done && !voice_mode);
	c_flush: cover property (@(posedge i_clk_sys) flush != MATCH_ZERO);
	c_busy_start: cover property (@(posedge i_clk_sys) state != ST_IDLE && i_id_start);
endmodule

// >>> verilog/vis_pkg.sv
// Package with constants and character and state types for the voice ID selector.
// Notes on behaviour
// - A message holding the voice marker is voice with Morse backup after it.
// - Carrier active at ID start: no playback, send the backup text in Morse.
// - Carrier inactive at ID start: trigger playback at the marker, skip backup.
// - No sensing of board presence; decision uses only marker and carrier state.
// - Characters ahead of the marker go out in Morse first.
package vis_pkg;
	localparam int unsigned CHAR_W = 8;
	localparam int unsigned ADDR_W = 6;
	localparam logic [CHAR_W-1:0] CH_COLON = 8'h3a;
	localparam logic [CHAR_W-1:0] CH_V_UP = 8'h56;
	localparam logic [CHAR_W-1:0] CH_V_LO = 8'h76;
	localparam logic [CHAR_W-1:0] CH_END = 8'h00;
	localparam int unsigned PULSE_CYC = 1;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 6'h01;
	localparam logic [1:0] MATCH_ZERO = 2'h0;
	localparam logic [1:0] MATCH_ONE = 2'h1;
	localparam logic [1:0] MATCH_TWO = 2'h2;

	typedef struct packed {
		logic valid;
		logic [CHAR_W-1:0] data;
	} vis_char_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WAIT,
		ST_SEND,
		ST_VOICE,
		ST_DONE
	} vis_state_t;
endpackage

// >>> verilog/vis_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
module vis_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_sync
);
	logic stage1;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// >>> tb/vis_voice_board.sv
// Behavioural voice playback board that plays a toggling audio burst after each trigger pulse.
module vis_voice_board (
	input wire logic i_clk_sys,
	input wire logic i_playback_button,
	output logic o_voice_audio
);
	timeunit 1ns;
	timeprecision 1ns;
	int left = 0;
	initial o_voice_audio = 1'b0;
	// The board offers no presence or recording status line, so the selector cannot sense it.
	always @(posedge i_clk_sys) begin
		if (i_playback_button === 1'b1) left <= 12;
		else if (left > 0) left <= left - 1;
		o_voice_audio <= (left > 0) ? ~o_voice_audio : 1'b0;
	end
endmodule

// >>> tb/vis_voice_id_selector_test.sv
// Self-checking bench for the voice ID selector with a message store and a stalling Morse sink.
module vis_voice_id_selector_test;
	timeunit 1ns;
	timeprecision 1ns;
	import vis_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, id_start = 1'b0, carrier = 1'b0, ready = 1'b0, prev_audio = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic rd, pulse, voice, tx_audio, voice_mode, busy, done;
	vis_char_t morse;
	logic [CHAR_W-1:0] mem [0:63];
	logic [CHAR_W-1:0] got [$];
	int err_count = 0, check_count = 0, pulses = 0, cyc = 0;
	initial forever #50 clk = ~clk;
	vis_voice_id_selector dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_id_start(id_start),
		.i_carrier_detect_input(carrier), .o_msg_addr(addr), .o_msg_rd(rd), .i_msg_data(mem[addr]),
		.o_morse(morse), .i_morse_ready(ready), .o_playback_button(pulse), .i_voice_audio(voice),
		.o_tx_audio(tx_audio), .o_voice_mode(voice_mode), .o_busy(busy), .o_done(done));
	vis_voice_board board (.i_clk_sys(clk), .i_playback_button(pulse), .o_voice_audio(voice));
	task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
		check_count++;
		if (got_v !== exp_v) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// The sink stalls every other cycle so that each character must stand until taken.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end else begin
			ready <= ~ready;
			if (morse.valid === 1'b1 && ready === 1'b1) got.push_back(morse.data);
			if (pulse === 1'b1) pulses++;
			if (rst_n === 1'b1) check({7'h00, tx_audio}, {7'h00, prev_audio});
			prev_audio <= voice;
		end
	end
	// A second start while busy must be ignored, so each run also repeats the start once.
	task automatic run(input string msg, input logic car, input string exp, input int exp_n, input logic mode);
		int i;
		for (i = 0; i < 64; i++) mem[i] = (i < msg.len()) ? msg[i] : CH_END;
		got.delete();
		pulses = 0;
		@(posedge clk) carrier <= car;
		repeat (3) @(posedge clk);
		@(posedge clk) id_start <= 1'b1;
		@(posedge clk) id_start <= 1'b0;
		@(posedge clk) id_start <= 1'b1;
		check({7'h00, busy}, 8'h01);
		check({7'h00, rd}, 8'h01);
		check({2'b00, addr}, 8'h00);
		@(posedge clk) id_start <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 2000) begin
			@(posedge clk);
			i++;
		end
		check({7'h00, done}, 8'h01);
		check({7'h00, busy}, 8'h00);
		@(posedge clk);
		check(8'(got.size()), 8'(exp.len()));
		for (i = 0; i < exp.len() && i < got.size(); i++) check(got[i], exp[i]);
		check(8'(pulses), 8'(exp_n));
		check({7'h00, voice_mode}, {7'h00, mode});
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		run("AB:V:CD", 1'b0, "AB", 1, 1'b1);
		run("AB:V:CD", 1'b1, "ABCD", 0, 1'b1);
		run(":v:XY", 1'b0, "", 1, 1'b1);
		run("A:VB", 1'b0, "A:VB", 0, 1'b0);
		run("N:V", 1'b1, "N:V", 0, 1'b0);
		end_sim();
	end
endmodule
